/* File: inc/dpa_pkg.sv */
/*
  Shared constants and types of the power-state and ADC sequencing block:
  register map, field layouts, reset values, timing counts and carriers.
  Assumes a 100 MHz system clock and a 32-bit classic Wishbone master.
*/
package dpa_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_CHAN   = 8'h04;
  localparam logic [7:0] OFS_ADC    = 8'h08;
  localparam logic [7:0] OFS_OFFSET = 8'h0C;
  localparam logic [7:0] OFS_DATA   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_POWER  = 8'h18;

  // ----------------------------------------------------------------
  // Power mode codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SLEEP   = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h1;
  localparam logic [1:0] MODE_IDLE    = 2'h2;
  localparam logic [1:0] MODE_RUN     = 2'h3;
  localparam logic [1:0] MODE_RST     = MODE_STANDBY;
  localparam logic [7:0] CHAN_RST     = 8'h00;
  localparam logic [7:0] ADC_RST      = 8'h00;
  localparam logic [15:0] OFFSET_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int unsigned STAT_READY = 0;
  localparam int unsigned STAT_CONV  = 1;
  localparam int unsigned STAT_CAL   = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ          = 100_000_000;
  localparam longint unsigned FIRST_RESULT_MS = 100;
  localparam longint unsigned RATE_SLOW_HZ    = 30;
  localparam longint unsigned RATE_FAST_HZ    = 60;
  localparam longint unsigned FIRST_CYCLES    = FIRST_RESULT_MS * CLK_HZ / 1000;
  localparam longint unsigned SLOW_CYCLES     = CLK_HZ / RATE_SLOW_HZ;
  localparam longint unsigned FAST_CYCLES     = CLK_HZ / RATE_FAST_HZ;
  localparam int unsigned     CNT_W           = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic always_on;
    logic low_vdd_mon;
    logic master_bias;
    logic pll;
    logic pll_clock_out;
    logic ext_supply_off_out;
    logic dac1;
    logic dac2;
    logic bandgap;
    logic bandgap_buf;
    logic sig_detect;
    logic adc_mux;
    logic adc_in_buf;
    logic adc;
  } dpa_power_type;

  typedef struct packed {
    logic       signed_input_select;
    logic       neg_input_buffer_en;
    logic       pos_input_buffer_en;
    logic [1:0] gain;
    logic       rate;
    logic       cal_select;
    logic       conversion_start_bit;
  } dpa_adc_ctrl_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } dpa_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } dpa_wb_rsp_type;

  typedef enum logic [1:0] {
    ADC_OFF,
    ADC_FIRST,
    ADC_CONV,
    ADC_CAL
  } dpa_adc_state_type;

endpackage

/* File: core/dpa_sync2.sv */
/*
  Two flip-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a level that stays put for at least two clocks.
*/
`timescale 1ns/1ns
module dpa_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpa_sync_state_type;

  dpa_sync_state_type state_reg;
  dpa_sync_state_type state_next;

  always_comb
  begin
    state_next    = state_reg;
    state_next.s1 = d_i;
    state_next.s2 = state_reg.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= '0;
    else if (ce_i)
      state_reg <= state_next;
  end

  assign q_o = state_reg.s2;

endmodule

/* File: core/dpa_link.sv */
/*
  Link-clock side of the raw sample path. Holds the latest modulator word
  and offers it to the system domain by a toggle handshake.
  Assumes raw words arrive on adc_clk_i; the word is not changed while
  an offer is outstanding, so the system side may read it directly.
*/
`timescale 1ns/1ns
module dpa_link (
  // Link clock and reset
  input  wire logic        adc_clk_i,
  input  wire logic        link_rst_i,
  // Modulator side
  input  wire logic        raw_valid_i,
  input  wire logic [15:0] raw_data_i,
  // System side
  input  wire logic        adc_power_i,
  input  wire logic        ack_tog_i,
  output logic             req_tog_o,
  output logic      [15:0] word_o
);

  typedef struct packed {
    logic        req;
    logic [15:0] word;
  } dpa_link_state_type;

  dpa_link_state_type state_reg;
  dpa_link_state_type state_next;
  logic [1:0]         sync_q;

  dpa_sync2 #(
    .W (2)
  ) u_sync (
    .clk_i (adc_clk_i),
    .rst_i (link_rst_i),
    .ce_i  (1'b1),
    .d_i   ({adc_power_i, ack_tog_i}),
    .q_o   (sync_q)
  );

  // Words that arrive while an offer is pending are dropped; the system
  // side only ever needs the most recent settled sample.
  always_comb
  begin
    state_next = state_reg;
    if (raw_valid_i && sync_q[1] && (sync_q[0] == state_reg.req))
    begin
      state_next.word = raw_data_i;
      state_next.req  = ~state_reg.req;
    end
  end

  always_ff @(posedge adc_clk_i)
  begin
    if (link_rst_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign req_tog_o = state_reg.req;
  assign word_o    = state_reg.word;

endmodule

/* File: core/dpa_top.sv */
/*
  Power-state decoder and ADC conversion / offset calibration sequencer.
  Registers are reached over classic Wishbone; raw samples come from the
  link-clock domain through dpa_link. Assumes the wake pins and the alarm
  are asynchronous levels and that the host keeps its own ordering.
*/
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
// Functional notes
// - Always-on blocks powered in every mode.
// - Standby upward powers bias, PLL, monitor, supply.
// - Wake-up powers standby blocks, leaves others unchanged.
// - Reset gives Standby and zeroed ADC settings.
// - First result ready first-result delay after start.
// - Conversions repeat at set rate until powered down.
// - Calibrate plus start does one calibration, stops.
// - Calibration result stored as two's complement offset.
// - Later results have offset subtracted.
// - Calibrate select clears itself after calibration.
// - Host-restored offset is subtracted like calibrated one.
`timescale 1ns/1ns
module dpa_top #(
  parameter int unsigned FIRST_CYCLES = int'(dpa_pkg::FIRST_CYCLES),
  parameter int unsigned SLOW_CYCLES  = int'(dpa_pkg::SLOW_CYCLES),
  parameter int unsigned FAST_CYCLES  = int'(dpa_pkg::FAST_CYCLES)
) (
  // System clock, reset, enable
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // Register bus
  input  wire dpa_pkg::dpa_wb_req_type wb_req_i,
  output dpa_pkg::dpa_wb_rsp_type      wb_rsp_o,
  // Wake-up sources
  input  wire logic                    wake1_n_i,
  input  wire logic                    wake2_n_i,
  input  wire logic                    alarm_i,
  // Link domain
  input  wire logic                    adc_clk_i,
  input  wire logic                    link_rst_i,
  input  wire logic                    raw_valid_i,
  input  wire logic [15:0]             raw_data_i,
  // Block power enables
  output dpa_pkg::dpa_power_type       power_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                 mode;
    dpa_pkg::dpa_power_type     pwr;
    logic [7:0]                 chan;
    dpa_pkg::dpa_adc_ctrl_type  adc;
    logic [15:0]                offset;
    logic [15:0]                data;
    logic [15:0]                raw;
    logic                       ack_tog;
    logic                       ready;
    logic                       wake_prev;
    dpa_pkg::dpa_adc_state_type st;
    logic [dpa_pkg::CNT_W-1:0]  cnt;
    dpa_pkg::dpa_wb_rsp_type    rsp;
  } dpa_top_state_type;

  dpa_top_state_type state_reg;
  dpa_top_state_type state_next;

  logic [3:0]  pin_q;
  logic        req_tog;
  logic [15:0] link_word;

  localparam logic [dpa_pkg::CNT_W-1:0] FIRST_CNT = dpa_pkg::CNT_W'(FIRST_CYCLES);
  localparam logic [dpa_pkg::CNT_W-1:0] SLOW_CNT  = dpa_pkg::CNT_W'(SLOW_CYCLES);
  localparam logic [dpa_pkg::CNT_W-1:0] FAST_CNT  = dpa_pkg::CNT_W'(FAST_CYCLES);
  localparam logic [dpa_pkg::CNT_W-1:0] CNT_ONE   = 24'h000001;

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  // The link's request toggle shares the pin synchroniser. The word that it
  // announces is held still by the link until acknowledged, so it is read without a synchroniser of its own.
  dpa_sync2 #(
    .W (4)
  ) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({req_tog, alarm_i, wake2_n_i, wake1_n_i}),
    .q_o   (pin_q)
  );

  dpa_link u_link (
    .adc_clk_i   (adc_clk_i),
    .link_rst_i  (link_rst_i),
    .raw_valid_i (raw_valid_i),
    .raw_data_i  (raw_data_i),
    .adc_power_i (state_reg.pwr.adc),
    .ack_tog_i   (state_reg.ack_tog),
    .req_tog_o   (req_tog),
    .word_o      (link_word)
  );

  // ----------------------------------------------------------------
  // Power table
  // ----------------------------------------------------------------
  // A mode write applies the whole table; a wake edge only patches it.
  function automatic dpa_pkg::dpa_power_type mode_power(input logic [1:0] m);
    dpa_pkg::dpa_power_type p;
    logic                   stby;
    logic                   idle;
    p    = '0;
    stby = (m != dpa_pkg::MODE_SLEEP);
    idle = (m == dpa_pkg::MODE_IDLE) || (m == dpa_pkg::MODE_RUN);
    p.always_on          = 1'b1;
    p.low_vdd_mon        = stby;
    p.master_bias        = stby;
    p.pll                = stby;
    p.pll_clock_out      = stby;
    p.ext_supply_off_out = stby;
    p.dac1               = idle;
    p.dac2               = idle;
    p.bandgap            = idle;
    p.bandgap_buf        = idle;
    p.sig_detect         = idle;
    p.adc_mux            = idle;
    p.adc_in_buf         = (m == dpa_pkg::MODE_RUN);
    p.adc                = (m == dpa_pkg::MODE_RUN);
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        bus_go;
  logic        wr;
  logic        wake_lvl;
  logic        wake_edge;
  logic        data_rd;
  logic        tick;
  logic        adc_wr;
  logic [31:0] rd;
  logic [dpa_pkg::CNT_W-1:0] period;

  always_comb
  begin
    state_next = state_reg;
    bus_go     = wb_req_i.cyc && wb_req_i.stb && !state_reg.rsp.ack;
    wr         = bus_go && wb_req_i.we;
    adc_wr     = wr && (wb_req_i.adr == dpa_pkg::OFS_ADC) && wb_req_i.sel[0];
    wake_lvl   = !pin_q[0] || !pin_q[1] || pin_q[2];
    period     = state_reg.adc.rate ? FAST_CNT : SLOW_CNT;
    wake_edge  = wake_lvl && !state_reg.wake_prev;
    data_rd    = bus_go && !wb_req_i.we && (wb_req_i.adr == dpa_pkg::OFS_DATA);
    tick       = (state_reg.cnt == CNT_ONE);
    rd         = 32'h00000000;

    // Raw sample handshake from the link domain.
    if (pin_q[3] != state_reg.ack_tog)
    begin
      state_next.raw     = link_word;
      state_next.ack_tog = pin_q[3];
    end

    // Register writes.
    if (wr)
    begin
      unique case (wb_req_i.adr)
        dpa_pkg::OFS_MODE:
        begin
          if (wb_req_i.sel[0])
          begin
            state_next.mode = wb_req_i.dat[1:0];
            state_next.pwr  = mode_power(wb_req_i.dat[1:0]);
          end
        end
        dpa_pkg::OFS_CHAN:
        begin
          if (wb_req_i.sel[0])
            state_next.chan = wb_req_i.dat[7:0];
        end
        dpa_pkg::OFS_ADC:
        begin
          if (wb_req_i.sel[0])
            state_next.adc = wb_req_i.dat[7:0];
        end
        dpa_pkg::OFS_OFFSET:
        begin
          if (wb_req_i.sel[0])
            state_next.offset[7:0] = wb_req_i.dat[7:0];
          if (wb_req_i.sel[1])
            state_next.offset[15:8] = wb_req_i.dat[15:8];
        end
        default:
        begin
        end
      endcase
    end

    // A wake edge only raises the standby-level blocks; the analog
    // enables keep whatever the last mode gave them.
    state_next.wake_prev = wake_lvl;
    if (wake_edge)
    begin
      state_next.pwr.low_vdd_mon        = 1'b1;
      state_next.pwr.master_bias        = 1'b1;
      state_next.pwr.pll                = 1'b1;
      state_next.pwr.pll_clock_out      = 1'b1;
      state_next.pwr.ext_supply_off_out = 1'b1;
      if (state_next.mode == dpa_pkg::MODE_SLEEP)
        state_next.mode = dpa_pkg::MODE_STANDBY;
    end

    // Data ready clears on a DATA read; a new result in the same cycle wins.
    if (data_rd)
      state_next.ready = 1'b0;

    // Conversion sequencer.
    if (state_reg.cnt != '0)
      state_next.cnt = state_reg.cnt - CNT_ONE;
    unique case (state_reg.st)
      dpa_pkg::ADC_OFF:
      begin
        if (state_reg.pwr.adc && state_reg.adc.conversion_start_bit)
        begin
          if (state_reg.adc.cal_select)
          begin
            state_next.st  = dpa_pkg::ADC_CAL;
            state_next.cnt = period;
          end
          else
          begin
            state_next.st  = dpa_pkg::ADC_FIRST;
            state_next.cnt = FIRST_CNT;
          end
        end
      end
      dpa_pkg::ADC_FIRST,
      dpa_pkg::ADC_CONV:
      begin
        if (tick)
        begin
          state_next.data  = state_reg.raw - state_reg.offset;
          state_next.ready = 1'b1;
          state_next.st    = dpa_pkg::ADC_CONV;
          state_next.cnt   = period;
        end
      end
      dpa_pkg::ADC_CAL:
      begin
        if (tick)
        begin
          // Calibration wins over a host offset write in the same cycle.
          state_next.offset                   = state_reg.raw;
          // A host ADC write in this same cycle keeps its own command bits,
          // otherwise the new command would be lost to the self-clear.
          if (!adc_wr)
          begin
            state_next.adc.cal_select           = 1'b0;
            state_next.adc.conversion_start_bit = 1'b0;
          end
          state_next.st                       = dpa_pkg::ADC_OFF;
          state_next.cnt                      = '0;
        end
      end
    endcase

    // A new ADC write restarts from the new settings; losing power ends
    // the run, and another start is needed once power returns.
    if (adc_wr)
    begin
      state_next.st  = dpa_pkg::ADC_OFF;
      state_next.cnt = '0;
    end
    if (!state_next.pwr.adc)
    begin
      state_next.st                       = dpa_pkg::ADC_OFF;
      state_next.cnt                      = '0;
      state_next.adc.conversion_start_bit = 1'b0;
    end

    // Read mux. It is decoded every cycle, but only a read's acknowledge
    // registers it, so the data lines rest at zero between reads.
    unique case (wb_req_i.adr)
      dpa_pkg::OFS_MODE:
      begin
        rd = {30'h00000000, state_reg.mode};
      end
      dpa_pkg::OFS_CHAN:
      begin
        rd = {24'h000000, state_reg.chan};
      end
      dpa_pkg::OFS_ADC:
      begin
        rd = {24'h000000, state_reg.adc};
      end
      dpa_pkg::OFS_OFFSET:
      begin
        rd = {16'h0000, state_reg.offset};
      end
      dpa_pkg::OFS_DATA:
      begin
        rd = {16'h0000, state_reg.data};
      end
      dpa_pkg::OFS_STATUS:
      begin
        rd[dpa_pkg::STAT_READY] = state_reg.ready;
        rd[dpa_pkg::STAT_CONV]  = (state_reg.st == dpa_pkg::ADC_FIRST) ||
                                  (state_reg.st == dpa_pkg::ADC_CONV);
        rd[dpa_pkg::STAT_CAL]   = (state_reg.st == dpa_pkg::ADC_CAL);
      end
      dpa_pkg::OFS_POWER:
      begin
        rd = {18'h00000, state_reg.pwr};
      end
      default:             rd = 32'h00000000;
    endcase

    // Every access, mapped or not, is answered one cycle later.
    state_next.rsp.ack = bus_go;
    state_next.rsp.dat = (bus_go && !wb_req_i.we) ? rd : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg           <= '0;
      state_reg.mode      <= dpa_pkg::MODE_RST;
      state_reg.pwr       <= mode_power(dpa_pkg::MODE_RST);
      state_reg.chan      <= dpa_pkg::CHAN_RST;
      state_reg.adc       <= dpa_pkg::ADC_RST;
      state_reg.offset    <= dpa_pkg::OFFSET_RST;
      state_reg.wake_prev <= 1'b1;
      state_reg.st        <= dpa_pkg::ADC_OFF;
    end
    else if (ce_i)
      state_reg <= state_next;
  end

  assign wb_rsp_o = state_reg.rsp;
  assign power_o  = state_reg.pwr;

endmodule

/* File: verification/dpa_mod_model.sv */
/*
  Behavioural modulator at the far side of the link: one raw word every
  fourth link clock. Assumes the bench sets the level that it reports.
*/
`timescale 1ns/1ns
module dpa_mod_model (
  // Link clock and reset
  input  wire logic        adc_clk_i,
  input  wire logic        link_rst_i,
  // Level to report
  input  wire logic [15:0] level_i,
  // Raw samples
  output logic             raw_valid_o,
  output logic      [15:0] raw_data_o
);
  logic [1:0] div_reg;

  // Between words the data lines toggle, so a design that samples them
  // without the valid pulse picks up garbage rather than a stale match.
  always_ff @(posedge adc_clk_i)
  begin
    if (link_rst_i)
    begin
      div_reg     <= 2'h0;
      raw_valid_o <= 1'b0;
      raw_data_o  <= 16'h0000;
    end
    else
    begin
      div_reg     <= div_reg + 2'h1;
      raw_valid_o <= (div_reg == 2'h3);
      raw_data_o  <= (div_reg == 2'h3) ? level_i : ~raw_data_o;
    end
  end
endmodule

/* File: verification/dpa_top_asserts.sv */
/*
  Port checker of dpa_top: power table, wake-up and bus answer.
  Assumes ce_i stays high while it is bound.
*/
`timescale 1ns/1ns
module dpa_top_asserts (
  // Clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  // Register bus
  input wire dpa_pkg::dpa_wb_req_type wb_req_i,
  input wire dpa_pkg::dpa_wb_rsp_type wb_rsp_o,
  // Wake sources and power enables
  input wire logic                    wake1_n_i,
  input wire logic                    wake2_n_i,
  input wire logic                    alarm_i,
  input wire dpa_pkg::dpa_power_type  power_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Power table; bits 12:8 are the standby group, 7:2 the analog group.
  // ----------------------------------------------------------------
  a_always_on_held: assert property (power_o.always_on)
    else $error("always-on group dropped");
  a_standby_group_tied: assert property (power_o[12:8] == 5'h00 || power_o[12:8] == 5'h1F)
    else $error("standby group split");
  a_analog_group_tied: assert property (power_o[7:2] == 6'h00 || power_o[7:2] == 6'h3F)
    else $error("analog group split");
  a_adc_needs_mux: assert property (power_o.adc_in_buf == power_o.adc && (!power_o.adc || power_o.adc_mux))
    else $error("converter enables inconsistent");
  a_analog_needs_bias: assert property (power_o.adc_mux |-> power_o.master_bias)
    else $error("analog powered without bias");
  a_reset_standby: assert property ($fell(rst_i) |-> power_o == 14'h3F00)
    else $error("power after reset not standby");

  // ----------------------------------------------------------------
  // Wake-up and bus answer
  // ----------------------------------------------------------------
  a_wake_raises: assert property (($fell(wake1_n_i) || $fell(wake2_n_i) || $rose(alarm_i))
    |-> ##[1:8] power_o[12:8] == 5'h1F)
    else $error("wake did not raise standby group");
  a_wake_keeps_analog: assert property (($fell(wake1_n_i) && !wb_req_i.cyc) |=> $stable(power_o[7:0]) [*8])
    else $error("wake changed analog enables");
  a_ack_one_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  a_ack_answers: assert property ((wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack) |=> wb_rsp_o.ack)
    else $error("request not answered next cycle");

  c_wake: cover property ($fell(wake1_n_i) ##[1:8] power_o.master_bias);
  c_run: cover property (power_o.adc);
  c_read: cover property (wb_rsp_o.ack && !wb_req_i.we);
endmodule

bind dpa_top dpa_top_asserts u_dpa_top_asserts (
  .clk_i     (clk_i),
  .rst_i     (rst_i),
  .wb_req_i  (wb_req_i),
  .wb_rsp_o  (wb_rsp_o),
  .wake1_n_i (wake1_n_i),
  .wake2_n_i (wake2_n_i),
  .alarm_i   (alarm_i),
  .power_o   (power_o)
);

/* File: verification/tb.sv */
/*
  Self-checking bench of dpa_top with a modulator model on the link.
  Assumes shortened sequencer counts and a free-running link clock.
*/
`timescale 1ns/1ns
module tb;
  localparam int FIRST = 200;
  localparam int SLOW  = 100;
  localparam int FAST  = 60;

  logic                    clk_i    = 1'b0;
  logic                    rst_i    = 1'b1;
  logic                    adc_clk  = 1'b0;
  logic                    link_rst = 1'b1;
  logic                    wake1_n  = 1'b1;
  logic                    wake2_n  = 1'b1;
  logic                    alarm    = 1'b0;
  logic [15:0]             level    = 16'h0000;
  logic                    raw_valid;
  logic [15:0]             raw_data;
  dpa_pkg::dpa_wb_req_type req      = '0;
  dpa_pkg::dpa_wb_rsp_type rsp;
  dpa_pkg::dpa_power_type  pwr;
  logic [31:0]             rd;
  int                      fail_count = 0;
  int                      n_tests    = 0;
  int                      cyc_now    = 0;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_now <= cyc_now + 1;
  initial
  begin
    #7;
    forever
    begin
      #62 adc_clk = 1'b1;
      #63 adc_clk = 1'b0;
    end
  end

  dpa_top #(.FIRST_CYCLES(FIRST), .SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) u_dpa_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_req_i(req), .wb_rsp_o(rsp),
    .wake1_n_i(wake1_n), .wake2_n_i(wake2_n), .alarm_i(alarm), .adc_clk_i(adc_clk),
    .link_rst_i(link_rst), .raw_valid_i(raw_valid), .raw_data_i(raw_data), .power_o(pwr));
  dpa_mod_model u_dpa_mod_model (.adc_clk_i(adc_clk), .link_rst_i(link_rst), .level_i(level),
    .raw_valid_o(raw_valid), .raw_data_o(raw_data));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: wd};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (rsp.ack !== 1'b1 && n < 20);
    rd = rsp.dat;
    req <= '0;
    if (n >= 20)
    begin
      check(32'h0, 32'h1, "bus answer wait");
      finish_test();
    end
  endtask

  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    wb(1'b0, adr, 32'h0);
    check(rd, exp, what);
  endtask

  // Polls status; the returned time is late by up to one read.
  task automatic wait_bit(input int idx, input logic val, output int t);
    int n;
    for (n = 0; n < 500; n++)
    begin
      wb(1'b0, dpa_pkg::OFS_STATUS, 32'h0);
      if (rd[idx] === val)
        break;
    end
    t = cyc_now;
    if (n == 500)
    begin
      check(32'h0, 32'h1, "status wait");
      finish_test();
    end
  endtask

  function automatic logic [31:0] exp_pwr(input logic [1:0] m);
    exp_pwr = {18'h0, 1'b1, {5{m != 2'h0}}, {6{m[1]}}, {2{m == 2'h3}}};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(dpa_pkg::OFS_MODE, 32'h1, "mode after reset");
    rchk(dpa_pkg::OFS_ADC, 32'h0, "converter settings after reset");
    rchk(dpa_pkg::OFS_POWER, exp_pwr(2'h1), "power after reset");
    rchk(8'h1C, 32'h0, "unmapped read");
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, dpa_pkg::OFS_MODE, 32'(m));
      rchk(dpa_pkg::OFS_POWER, exp_pwr(2'(m)), "power register");
      check({18'h0, pwr}, exp_pwr(2'(m)), "power pins");
    end
  endtask

  task automatic t_wake();
    for (int s = 0; s < 3; s++)
    begin
      wb(1'b1, dpa_pkg::OFS_MODE, (s == 2) ? 32'h3 : 32'h0);
      @(posedge clk_i);
      wake1_n <= (s != 0);
      wake2_n <= (s != 1);
      alarm <= (s == 2);
      repeat (12) @(posedge clk_i);
      rchk(dpa_pkg::OFS_POWER, exp_pwr((s == 2) ? 2'h3 : 2'h1), "power after wake");
      wake1_n <= 1'b1;
      wake2_n <= 1'b1;
      alarm <= 1'b0;
    end
  endtask

  task automatic t_convert();
    int t0;
    int t1;
    int t2;
    int p;
    wb(1'b1, dpa_pkg::OFS_MODE, 32'h3);
    wb(1'b1, dpa_pkg::OFS_CHAN, 32'h94);
    level <= 16'h1234;
    repeat (100) @(posedge clk_i);
    for (int r = 0; r < 2; r++)
    begin
      p = r ? FAST : SLOW;
      wb(1'b1, dpa_pkg::OFS_ADC, r ? 32'h05 : 32'h01);
      t0 = cyc_now;
      wb(1'b0, dpa_pkg::OFS_DATA, 32'h0);
      wait_bit(dpa_pkg::STAT_READY, 1'b1, t1);
      check(32'(t1 - t0 >= FIRST - 2 && t1 - t0 <= FIRST + 12), 32'h1, "first result delay");
      rchk(dpa_pkg::OFS_DATA, 32'h1234, "result");
      wait_bit(dpa_pkg::STAT_READY, 1'b1, t2);
      check(32'(t2 - t1 >= p - 8 && t2 - t1 <= p + 8), 32'h1, "conversion period");
    end
  endtask

  task automatic t_calibrate();
    int t;
    level <= 16'h0100;
    repeat (100) @(posedge clk_i);
    wb(1'b1, dpa_pkg::OFS_ADC, 32'h03);
    wait_bit(dpa_pkg::STAT_CAL, 1'b1, t);
    wait_bit(dpa_pkg::STAT_CAL, 1'b0, t);
    rchk(dpa_pkg::OFS_OFFSET, 32'h0100, "stored offset");
    rchk(dpa_pkg::OFS_ADC, 32'h0, "calibrate select cleared");
    repeat (2 * SLOW) @(posedge clk_i);
    wb(1'b0, dpa_pkg::OFS_STATUS, 32'h0);
    check(rd & 32'h6, 32'h0, "converter stopped after calibration");
    level <= 16'h0050;
    repeat (100) @(posedge clk_i);
    wb(1'b1, dpa_pkg::OFS_ADC, 32'h01);
    wb(1'b0, dpa_pkg::OFS_DATA, 32'h0);
    wait_bit(dpa_pkg::STAT_READY, 1'b1, t);
    rchk(dpa_pkg::OFS_DATA, 32'h0000FF50, "calibrated result");
  endtask

  task automatic t_restore();
    int t;
    wb(1'b1, dpa_pkg::OFS_OFFSET, 32'h0010);
    wb(1'b1, dpa_pkg::OFS_ADC, 32'h01);
    wb(1'b0, dpa_pkg::OFS_DATA, 32'h0);
    wait_bit(dpa_pkg::STAT_READY, 1'b1, t);
    rchk(dpa_pkg::OFS_DATA, 32'h0040, "restored offset result");
    wb(1'b1, dpa_pkg::OFS_MODE, 32'h2);
    rchk(dpa_pkg::OFS_ADC, 32'h0, "start cleared on leaving run");
  endtask

  initial
  begin
    repeat (3) @(posedge adc_clk);
    link_rst <= 1'b0;
  end

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_modes();
    t_wake();
    t_convert();
    t_calibrate();
    t_restore();
    finish_test();
  end
endmodule
